// >>> hw/atsc_defines.vh
// Constants for the converter and temperature sensor control block
//
// Overview of operation
// - Write one starts; reads one when finished
// - Input select routes sensor, pins, ground
// - Reference select: bandgap, supply/3, supply/2
// - Differential full scale scales with gain
// - Amplifier offset: three-bit magnitude, sign bit
// - Result register read-only, latest conversion value
// - Range field sets temperature scaling per step
// - Kelvin offset enable, only bit set
// - Trim enable applies four-bit trim value
// - Signed temperature value offset added
`ifndef ATSC_DEFINES_VH
`define ATSC_DEFINES_VH

// ****************************************
// Register offsets
// ****************************************
`define ATSC_OFS_CONFIG    8'h0f
`define ATSC_OFS_AMPOFFS   8'h10
`define ATSC_OFS_RESULT    8'h11
`define ATSC_OFS_CAL       8'h12
`define ATSC_OFS_TVOFFS    8'h13
`define ATSC_OFS_IRQ_STAT  8'h20
`define ATSC_OFS_IRQ_MASK  8'h21

// ****************************************
// Field positions
// ****************************************
`define ATSC_CFG_START     7
`define ATSC_CFG_SEL_HI    6
`define ATSC_CFG_SEL_LO    4
`define ATSC_CFG_REF_HI    3
`define ATSC_CFG_REF_LO    2
`define ATSC_CFG_GAIN_HI   1
`define ATSC_CFG_GAIN_LO   0
`define ATSC_AOF_HI        3
`define ATSC_CAL_RANGE_HI  7
`define ATSC_CAL_RANGE_LO  6
`define ATSC_CAL_KELVIN    5
`define ATSC_CAL_TRIM_EN   4
`define ATSC_CAL_TRIM_HI   3
`define ATSC_IRQ_DONE      0

// ****************************************
// Encodings and reset values
// ****************************************
`define ATSC_SEL_TEMP      3'h0
`define ATSC_SEL_GND       3'h7
`define ATSC_RST_CONFIG    7'h00
`define ATSC_RST_AMPOFFS   4'h0
`define ATSC_RST_RESULT    8'h00
`define ATSC_RST_CAL       8'h20
`define ATSC_RST_TVOFFS    8'h00
`define ATSC_RST_IRQ       1'h0

`endif

// >>> hw/atsc_sync.v
// Three-stage synchroniser with agreement filter for the converter done input
`timescale 1ns/10ps
module atsc_sync (
  // Clock and reset
  input  wire clk,
  input  wire srst,
  // Asynchronous level in, filtered level out
  input  wire din,
  output reg  dout
);

  reg s1_reg;
  reg s2_reg;
  reg s3_reg;

  // First stage feeds only the second
  always @(posedge clk) begin
    // Idle-high reset: no false fall of done right after reset
    if (srst) begin
      s1_reg <= 1'b1;
      s2_reg <= 1'b1;
      s3_reg <= 1'b1;
      dout   <= 1'b1;
    end else begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        dout <= s3_reg;
      end
    end
  end

endmodule

// >>> hw/atsc_post.v
// Digital correction of temperature sensor codes
`timescale 1ns/10ps
`include "atsc_defines.vh"
module atsc_post (
  // Raw code and source select
  input  wire [7:0] raw_code,
  input  wire [2:0] src_sel,
  // Correction controls
  input  wire       trim_en,
  input  wire [3:0] trim_val,
  input  wire [7:0] value_offs,
  // Corrected code
  output reg  [7:0] code_out
);

  // Sign-extend an eight-bit two's complement to ten bits
  function [9:0] sext8;
    input [7:0] v;
    begin
      sext8 = {{2{v[7]}}, v};
    end
  endfunction

  reg [9:0] sum;

  always @* begin
    sum = {2'b00, raw_code};
    if (src_sel == `ATSC_SEL_TEMP) begin
      if (trim_en) begin
        sum = sum + sext8({{4{trim_val[3]}}, trim_val});
      end
      sum = sum + sext8(value_offs);
    end
    // Saturate rather than wrap: a wrapped reading flips hot to cold
    if (sum[9]) begin
      code_out = 8'h00;
    end else if (sum[8]) begin
      code_out = 8'hff;
    end else begin
      code_out = sum[7:0];
    end
  end

endmodule

// >>> hw/atsc_ctrl.v
// Converter and temperature sensor control with register port
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/10ps
`include "atsc_defines.vh"
module atsc_ctrl (
  // Clock and reset
  input  wire       clk,
  input  wire       srst,
  // Register port
  input  wire [7:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_we,
  input  wire       reg_re,
  output reg  [7:0] reg_rdata,
  // Interrupt
  output wire       irq,
  // Converter handshake
  output reg        conv_start,
  input  wire       conv_done,
  input  wire [7:0] conv_code,
  // Analog front end controls
  output wire [2:0] src_sel,
  output wire [1:0] ref_sel,
  output wire [1:0] amp_gain,
  output wire [3:0] amp_offs,
  output wire [1:0] ts_range,
  output wire       kelvin_en
);

  // ****************************************
  // State encoding
  // ****************************************
  localparam [2:0] ST_IDLE     = 3'b001;
  localparam [2:0] ST_WAIT_CLR = 3'b010;
  localparam [2:0] ST_WAIT_SET = 3'b100;

  // ****************************************
  // Registers
  // ****************************************
  reg  [6:0] config_reg;
  reg  [3:0] amp_offset_setting_reg;
  reg  [7:0] converter_result_reg;
  reg  [7:0] temp_sensor_calibration_reg;
  reg  [7:0] temp_value_offset_reg;
  reg        done_reg;
  reg        irq_stat_reg;
  reg        irq_mask_reg;
  reg  [2:0] state_reg;
  reg  [2:0] state_next;
  reg  [7:0] rdata_next;
  wire       done_sync;
  wire [7:0] corrected;
  wire       wr_cfg;
  wire       wr_aof;
  wire       wr_cal;
  wire       wr_tvo;
  wire       wr_stat;
  wire       wr_mask;
  wire       clr_stat;
  wire       start_req;
  wire       finish;

  // ****************************************
  // Converter done from the analog side
  // ****************************************
  atsc_sync u_done_sync (
    .clk  (clk),
    .srst (srst),
    .din  (conv_done),
    .dout (done_sync)
  );

  // ****************************************
  // Sensor reading correction
  // ****************************************
  // Only the temperature source is corrected; pin readings pass raw
  atsc_post u_post (
    .raw_code   (conv_code),
    .src_sel    (src_sel),
    .trim_en    (temp_sensor_calibration_reg[`ATSC_CAL_TRIM_EN]),
    .trim_val   (temp_sensor_calibration_reg[`ATSC_CAL_TRIM_HI:0]),
    .value_offs (temp_value_offset_reg),
    .code_out   (corrected)
  );

  // ****************************************
  // Front end control outputs
  // ****************************************
  assign src_sel   = config_reg[`ATSC_CFG_SEL_HI:`ATSC_CFG_SEL_LO];
  assign ref_sel   = config_reg[`ATSC_CFG_REF_HI:`ATSC_CFG_REF_LO];
  // Full scale in differential modes follows gain and ref_sel[0]
  assign amp_gain  = config_reg[`ATSC_CFG_GAIN_HI:`ATSC_CFG_GAIN_LO];
  assign amp_offs  = amp_offset_setting_reg;
  assign ts_range  =
    temp_sensor_calibration_reg[`ATSC_CAL_RANGE_HI:`ATSC_CAL_RANGE_LO];
  assign kelvin_en = temp_sensor_calibration_reg[`ATSC_CAL_KELVIN];

  // ****************************************
  // Address decode
  // ****************************************
  // Shared compare keeps every write strobe decode identical
  function hit;
    input       strobe;
    input [7:0] addr;
    input [7:0] offset;
    begin
      hit = strobe && (addr == offset);
    end
  endfunction

  assign wr_cfg   = hit(reg_we, reg_addr, `ATSC_OFS_CONFIG);
  assign wr_aof   = hit(reg_we, reg_addr, `ATSC_OFS_AMPOFFS);
  assign wr_cal   = hit(reg_we, reg_addr, `ATSC_OFS_CAL);
  assign wr_tvo   = hit(reg_we, reg_addr, `ATSC_OFS_TVOFFS);
  assign wr_stat  = hit(reg_we, reg_addr, `ATSC_OFS_IRQ_STAT);
  assign wr_mask  = hit(reg_we, reg_addr, `ATSC_OFS_IRQ_MASK);
  // Only a one in the done position clears; zeros leave it alone
  assign clr_stat = wr_stat && reg_wdata[`ATSC_IRQ_DONE];

  // ****************************************
  // Conversion sequencer
  // ****************************************
  // Start while busy is ignored; the running conversion completes
  assign start_req = wr_cfg && reg_wdata[`ATSC_CFG_START]
                     && (state_reg == ST_IDLE);
  // Old done must fall first so a stale level is not taken as new
  assign finish    = (state_reg == ST_WAIT_SET) && done_sync;

  // ****************************************
  // Next-state logic
  // ****************************************
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (start_req) begin
          state_next = ST_WAIT_CLR;
        end
      end
      ST_WAIT_CLR: begin
        if (!done_sync) begin
          state_next = ST_WAIT_SET;
        end
      end
      ST_WAIT_SET: begin
        if (done_sync) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // ****************************************
  // State register and start pulse
  // ****************************************
  always @(posedge clk) begin
    if (srst) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Registered pulse: the converter never sees a decode glitch
  always @(posedge clk) begin
    if (srst) begin
      conv_start <= 1'b0;
    end else begin
      conv_start <= start_req;
    end
  end

  // ****************************************
  // Start/done status bit
  // ****************************************
  // Resets to one: an idle converter reads as finished
  always @(posedge clk) begin
    if (srst) begin
      done_reg <= 1'b1;
    end else if (start_req) begin
      done_reg <= 1'b0;
    end else if (finish) begin
      done_reg <= 1'b1;
    end
  end

  // ****************************************
  // Configuration register
  // ****************************************
  // Bits 6:0 take every write; a refused start still updates them
  always @(posedge clk) begin
    if (srst) begin
      config_reg <= `ATSC_RST_CONFIG;
    end else if (wr_cfg) begin
      config_reg <= reg_wdata[6:0];
    end
  end

  // ****************************************
  // Amplifier offset register
  // ****************************************
  // Reserved upper bits are not stored
  always @(posedge clk) begin
    if (srst) begin
      amp_offset_setting_reg <= `ATSC_RST_AMPOFFS;
    end else if (wr_aof) begin
      amp_offset_setting_reg <= reg_wdata[`ATSC_AOF_HI:0];
    end
  end

  // ****************************************
  // Calibration and value offset registers
  // ****************************************
  // Range and offset enable go out unchanged; trim feeds correction
  always @(posedge clk) begin
    if (srst) begin
      temp_sensor_calibration_reg <= `ATSC_RST_CAL;
    end else if (wr_cal) begin
      temp_sensor_calibration_reg <= reg_wdata;
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      temp_value_offset_reg <= `ATSC_RST_TVOFFS;
    end else if (wr_tvo) begin
      temp_value_offset_reg <= reg_wdata;
    end
  end

  // ****************************************
  // Result capture
  // ****************************************
  // No write path: software cannot disturb a finished reading
  always @(posedge clk) begin
    if (srst) begin
      converter_result_reg <= `ATSC_RST_RESULT;
    end else if (finish) begin
      converter_result_reg <= corrected;
    end
  end

  // ****************************************
  // Interrupt status and mask
  // ****************************************
  // Set wins over a write-one clear in the same cycle
  always @(posedge clk) begin
    if (srst) begin
      irq_stat_reg <= `ATSC_RST_IRQ;
    end else if (finish) begin
      irq_stat_reg <= 1'b1;
    end else if (clr_stat) begin
      irq_stat_reg <= 1'b0;
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      irq_mask_reg <= `ATSC_RST_IRQ;
    end else if (wr_mask) begin
      irq_mask_reg <= reg_wdata[`ATSC_IRQ_DONE];
    end
  end

  // ****************************************
  // Interrupt output
  // ****************************************
  // Level output, held until software clears the status bit or the mask bit
  assign irq = irq_stat_reg && irq_mask_reg;

  // ****************************************
  // Register reads
  // ****************************************
  always @* begin
    rdata_next = 8'h00;
    case (reg_addr)
      `ATSC_OFS_CONFIG:   rdata_next = {done_reg, config_reg};
      `ATSC_OFS_AMPOFFS:  rdata_next = {4'h0, amp_offset_setting_reg};
      `ATSC_OFS_RESULT:   rdata_next = converter_result_reg;
      `ATSC_OFS_CAL:      rdata_next = temp_sensor_calibration_reg;
      `ATSC_OFS_TVOFFS:   rdata_next = temp_value_offset_reg;
      `ATSC_OFS_IRQ_STAT: rdata_next = {7'h00, irq_stat_reg};
      `ATSC_OFS_IRQ_MASK: rdata_next = {7'h00, irq_mask_reg};
      default:            rdata_next = 8'h00;
    endcase
  end

  // ****************************************
  // Read data register
  // ****************************************
  // Zero outside its cycle keeps an OR-ed read bus clean
  always @(posedge clk) begin
    if (srst) begin
      reg_rdata <= 8'h00;
    end else if (reg_re) begin
      reg_rdata <= rdata_next;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule

// >>> tb/atsc_ctrl_asserts.sv
// Checker for the converter control block ports
`timescale 1ns/10ps
module atsc_ctrl_chk (
  // Clock and reset
  input wire       clk,
  input wire       srst,
  // Register port
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire       reg_we,
  input wire       reg_re,
  input wire [7:0] reg_rdata,
  // Converter side
  input wire       irq,
  input wire       conv_start,
  input wire       conv_done,
  input wire [7:0] conv_code,
  input wire [2:0] src_sel,
  input wire [1:0] ref_sel,
  input wire [1:0] amp_gain,
  input wire [3:0] amp_offs,
  input wire [1:0] ts_range,
  input wire       kelvin_en
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  // ****************************************
  // Named steps
  // ****************************************
  sequence s_wcfg;
    reg_we && reg_addr == 8'h0f;
  endsequence
  sequence s_rcfg;
    reg_re && reg_addr == 8'h0f;
  endsequence
  a_start_one: assert property (conv_start |=> !conv_start)
    else $error("start pulse longer than one cycle");
  a_start_cause: assert property (conv_start |-> $past(reg_we) &&
    $past(reg_addr) == 8'h0f && $past(reg_wdata[7]))
    else $error("start pulse without start write");
  a_cfg_write: assert property (s_wcfg |=>
    {src_sel, ref_sel, amp_gain} == $past(reg_wdata[6:0]))
    else $error("config controls differ from write");
  a_cfg_keep: assert property (!(reg_we && reg_addr == 8'h0f) |=>
    $stable({src_sel, ref_sel, amp_gain}))
    else $error("config controls moved without write");
  a_offs_write: assert property (reg_we && reg_addr == 8'h10 |=>
    amp_offs == $past(reg_wdata[3:0]))
    else $error("offset control differs from write");
  a_cal_write: assert property (reg_we && reg_addr == 8'h12 |=>
    {ts_range, kelvin_en} == $past(reg_wdata[7:5]))
    else $error("range or offset enable differs from write");
  a_rdata_idle: assert property (!reg_re |=> reg_rdata == 8'h00)
    else $error("read data outside its cycle");
  a_busy_read: assert property (conv_start ##1 s_rcfg |=>
    !reg_rdata[7])
    else $error("done bit set while busy");
  a_irq_cause: assert property ($rose(irq) |->
    $past(conv_done) || $past(reg_we))
    else $error("interrupt rose without cause");
endmodule
bind atsc_ctrl atsc_ctrl_chk i_chk (.clk(clk), .srst(srst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
  .reg_re(reg_re), .reg_rdata(reg_rdata), .irq(irq),
  .conv_start(conv_start), .conv_done(conv_done), .conv_code(conv_code),
  .src_sel(src_sel), .ref_sel(ref_sel), .amp_gain(amp_gain),
  .amp_offs(amp_offs), .ts_range(ts_range), .kelvin_en(kelvin_en));

// >>> tb/atsc_conv_model.sv
// Behavioural converter answering start pulses
`timescale 1ns/10ps
module atsc_conv_model (
  // Clock
  input  wire       clk,
  // Handshake
  input  wire       conv_start,
  output reg        conv_done,
  output reg  [7:0] conv_code,
  // Bench controls
  input  wire [7:0] lat,
  input  wire [7:0] code_in
);
  integer n;
  initial begin
    conv_done = 1'b1;
    conv_code = 8'h00;
  end
  // Code churns while low so a stale value is never taken
  always @(posedge clk) begin
    if (conv_start) begin
      repeat (2) @(posedge clk);
      conv_done <= 1'b0;
      for (n = 0; n < lat; n = n + 1) begin
        @(posedge clk);
        conv_code <= ~conv_code;
      end
      @(posedge clk);
      conv_code <= code_in;
      @(posedge clk);
      conv_done <= 1'b1;
    end
  end
endmodule

// >>> tb/test_atsc_ctrl.sv
// Bench for the converter control block
`timescale 1ns/10ps
module test_atsc_ctrl;
  logic       clk = 1'b0, srst = 1'b1, reg_we = 1'b0, reg_re = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, v, cfg, pr = 8'h00;
  logic [7:0] lat = 8'h08, code_in = 8'h00;
  logic       m = 1'b0;
  logic [7:0] ra [7] = '{8'h0f, 8'h10, 8'h11, 8'h12, 8'h13, 8'h20, 8'h21};
  logic [7:0] rv [7] = '{8'h80, 8'h00, 8'h00, 8'h20, 8'h00, 8'h00, 8'h00};
  wire  [7:0] reg_rdata, conv_code;
  wire  [3:0] amp_offs;
  wire  [2:0] src_sel;
  wire  [1:0] ref_sel, amp_gain, ts_range;
  wire        irq, conv_start, conv_done, kelvin_en;
  integer     fail_count = 0, samples_checked = 0, starts = 0, i;
  always #2 clk = ~clk;
  always @(posedge clk) if (conv_start) starts <= starts + 1;
  atsc_ctrl i_atsc_ctrl (.clk(clk), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
    .reg_rdata(reg_rdata), .irq(irq), .conv_start(conv_start),
    .conv_done(conv_done), .conv_code(conv_code), .src_sel(src_sel),
    .ref_sel(ref_sel), .amp_gain(amp_gain), .amp_offs(amp_offs),
    .ts_range(ts_range), .kelvin_en(kelvin_en));
  atsc_conv_model i_atsc_conv_model (.clk(clk), .conv_start(conv_start),
    .conv_done(conv_done), .conv_code(conv_code), .lat(lat),
    .code_in(code_in));
  // ****************************************
  // Access and compare tasks
  // ****************************************
  task automatic chk(input string nm, input logic [7:0] s, e);
    samples_checked++;
    if (s !== e) begin
      fail_count++;
      $display("[FAIL] %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_we <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_re <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task automatic rc(input logic [7:0] a, e);
    rd(a);
    chk($sformatf("reg %h", a), v, e);
  endtask
  task automatic conv(input logic [7:0] c, input logic [7:0] c2, e);
    integer n, s0;
    s0 = starts;
    code_in <= c2;
    wr(8'h0f, c | 8'h80);
    rc(8'h0f, c & 8'h7f);
    rc(8'h11, pr);
    wr(8'h0f, c | 8'h80);
    v = 8'h00;
    for (n = 0; n < 60 && !v[7]; n++) rd(8'h0f);
    chk("done", v, c | 8'h80);
    chk("starts", 8'(starts - s0), 8'h01);
    rc(8'h11, e);
    rc(8'h20, 8'h01);
    chk("irq", irq, m);
    wr(8'h20, 8'h01);
    rc(8'h20, 8'h00);
    chk("irq", irq, 8'h00);
    pr = e;
  endtask
  task automatic summarize;
    if (fail_count == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #100000;
    fail_count++;
    summarize();
  end
  initial begin
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    for (i = 0; i < 7; i++) rc(ra[i], rv[i]);
    chk("kelvin", kelvin_en, 8'h01);
    wr(8'h30, 8'hff);
    rc(8'h30, 8'h00);
    wr(8'h11, 8'hff);
    rc(8'h11, 8'h00);
    wr(8'h10, 8'hff);
    rc(8'h10, 8'h0f);
    chk("offs", amp_offs, 8'h0f);
    wr(8'h12, 8'hdf);
    rc(8'h12, 8'hdf);
    chk("range", {ts_range, kelvin_en}, 8'h06);
    for (i = 0; i < 8; i++) begin
      cfg = 8'(i * 16 + (i % 4) * 5);
      wr(8'h0f, cfg);
      rc(8'h0f, cfg | 8'h80);
      chk("sel", {src_sel, ref_sel, amp_gain}, cfg);
    end
    m = 1'b1;
    wr(8'h21, 8'h01);
    conv(8'h10, 8'h5a, 8'h5a);
    lat <= 8'h28;
    conv(8'h30, 8'hc3, 8'hc3);
    wr(8'h13, 8'h05);
    wr(8'h12, 8'h1f);
    conv(8'h00, 8'h40, 8'h44);
    wr(8'h12, 8'h0f);
    conv(8'h00, 8'h40, 8'h45);
    wr(8'h13, 8'h7f);
    conv(8'h00, 8'hf0, 8'hff);
    wr(8'h13, 8'h80);
    conv(8'h00, 8'h10, 8'h00);
    m = 1'b0;
    wr(8'h21, 8'h00);
    conv(8'h70, 8'h33, 8'h33);
    // Reset while idle after the last conversion, then a start as early as the port allows
    @(posedge clk);
    srst <= 1'b1;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    pr = 8'h00;
    conv(8'h10, 8'h66, 8'h66);
    chk("kelvin", kelvin_en, 8'h01);
    summarize();
  end
endmodule
